// ===== rtl/user_serial_port.v
// User-defined serial port: program-controlled transmitter and message receiver.
`timescale 1ns/1ps
`include "user_serial_port_regs.vh"
module user_serial_port #(
  parameter [23:0] BAUD_DIV       = `BAUD_DIV_DEFAULT,
  parameter [23:0] TURNAROUND_CYC = `TURNAROUND_CYC,
  parameter [23:0] IDLE_END_CYC   = `IDLE_END_DEFAULT
) (
  input  wire        clk,
  input  wire        resetn,
  input  wire        run_mode,
  input  wire        port_sel,
  input  wire [7:0]  port0_user_mode_control,
  input  wire [7:0]  port1_user_mode_control,
  input  wire        message_transmit_op,
  input  wire [7:0]  tx_len,
  output reg  [7:0]  tx_rd_addr,
  input  wire [7:0]  tx_rd_data,
  output wire        tx_busy,
  output reg         tx_done_irq,
  input  wire        message_receive_op,
  input  wire        rx_start_chr_en,
  input  wire [7:0]  rx_start_chr,
  input  wire        rx_end_chr_en,
  input  wire [7:0]  rx_end_chr,
  output reg         rx_chr_irq,
  output reg  [7:0]  rx_chr,
  output reg         rx_wr_en,
  output reg  [7:0]  rx_wr_addr,
  output reg  [7:0]  rx_wr_data,
  output reg         rx_done_irq,
  output reg  [7:0]  rx_msg_len,
  output wire        default_programming_protocol,
  input  wire        rxd_pin,
  output reg         txd_pin
);
  // ************************************************************
  // Mode selection
  // ************************************************************
  localparam TX_IDLE = 2'h0;
  localparam TX_WAIT = 2'h1;
  localparam TX_SEND = 2'h2;
  localparam RX_OFF  = 2'h0;
  localparam RX_HUNT = 2'h1;
  localparam RX_COLL = 2'h2;

  wire [7:0] ctl = port_sel ? port1_user_mode_control : port0_user_mode_control;
  wire user_mode = run_mode & ctl[`UCTL_ENABLE_BIT];
  assign default_programming_protocol = ~user_mode;

  // Parity of a character, shared by both directions.
  function par_of(input [7:0] d, input odd);
    par_of = ^d ^ odd;
  endfunction

  // ************************************************************
  // Receive line synchroniser and character deframer
  // ************************************************************
  reg        rxs1_q, rxs2_q;
  reg [23:0] rx_cnt_q;
  reg [3:0]  rx_bit_q;
  reg [9:0]  rx_sh_q;
  reg        rx_act_q;
  reg        chr_vld_q;
  wire [3:0] rx_nbits = ctl[`UCTL_PARITY_EN] ? `DATA_BITS + 4'h2 : `DATA_BITS + 4'h1;

  // framing: sample mid-bit, accept only with a good stop bit and, when parity is enabled, a good parity bit.
  always @(posedge clk) begin
    rxs1_q    <= rxd_pin;
    rxs2_q    <= rxs1_q;
    chr_vld_q <= 1'b0;
    if (!resetn || !user_mode) begin
      rxs1_q   <= 1'b1;
      rxs2_q   <= 1'b1;
      rx_act_q <= 1'b0;
      rx_cnt_q <= 24'h000000;
      rx_bit_q <= 4'h0;
      rx_sh_q  <= 10'h000;
    end else if (!rx_act_q) begin
      if (!rxs2_q) begin
        rx_act_q <= 1'b1;
        rx_cnt_q <= {1'b0, BAUD_DIV[23:1]};
        rx_bit_q <= 4'h0;
      end
    end else if (rx_cnt_q != 24'h000000) begin
      rx_cnt_q <= rx_cnt_q - 24'h000001;
    end else begin
      rx_cnt_q <= BAUD_DIV - 24'h000001;
      rx_sh_q  <= {rxs2_q, rx_sh_q[9:1]};
      rx_bit_q <= rx_bit_q + 4'h1;
      if (rx_bit_q == 4'h0 && rxs2_q)
        rx_act_q <= 1'b0;
      else if (rx_bit_q == rx_nbits) begin
        rx_act_q  <= 1'b0;
        chr_vld_q <= rxs2_q & (!ctl[`UCTL_PARITY_EN] ||
                     (rx_sh_q[9] == par_of(rx_sh_q[8:1], ctl[`UCTL_PARITY_ODD])));
      end
    end
  end
  // The stop bit is the last one shifted in, so the character sits just below it (and below parity).
  wire [7:0] chr_now = ctl[`UCTL_PARITY_EN] ? rx_sh_q[7:0] : rx_sh_q[8:1];

  // ************************************************************
  // Message receiver
  // ************************************************************
  reg [1:0]  rx_st_q;
  reg [23:0] idle_q;
  reg [23:0] turn_q;

  always @(posedge clk) begin
    rx_chr_irq  <= 1'b0;
    rx_wr_en    <= 1'b0;
    rx_done_irq <= 1'b0;
    if (!resetn || !user_mode) begin
      rx_st_q    <= RX_OFF;
      rx_chr     <= 8'h00;
      rx_wr_addr <= 8'h00;
      rx_wr_data <= 8'h00;
      rx_msg_len <= 8'h00;
      idle_q     <= 24'h000000;
      turn_q     <= 24'h000000;
    end else begin
      if (rx_act_q)
        idle_q <= 24'h000000;
      else if (idle_q != IDLE_END_CYC)
        idle_q <= idle_q + 24'h000001;
      if (turn_q != 24'h000000)
        turn_q <= turn_q - 24'h000001;
      if (chr_vld_q) begin
        rx_chr     <= chr_now;
        rx_chr_irq <= 1'b1;
        turn_q     <= TURNAROUND_CYC;
      end
      case (rx_st_q)
        RX_OFF: begin
          if (message_receive_op) begin
            rx_st_q    <= rx_start_chr_en ? RX_HUNT : RX_COLL;
            rx_wr_addr <= 8'h00;
          end
        end
        RX_HUNT: begin
          if (chr_vld_q && chr_now == rx_start_chr) begin
            rx_st_q    <= RX_COLL;
            rx_wr_en   <= 1'b1;
            rx_wr_data <= chr_now;
            rx_wr_addr <= 8'h01;
          end
        end
        RX_COLL: begin
          if (chr_vld_q) begin
            rx_wr_en   <= 1'b1;
            rx_wr_data <= chr_now;
            rx_wr_addr <= rx_wr_addr + 8'h01;
            if ((rx_end_chr_en && chr_now == rx_end_chr) || rx_wr_addr == `MAX_MSG_LEN - 8'h01) begin
              rx_st_q     <= RX_OFF;
              rx_done_irq <= 1'b1;
              rx_msg_len  <= rx_wr_addr + 8'h01;
            end
          end else if (!rx_end_chr_en && rx_wr_addr != 8'h00 && idle_q == IDLE_END_CYC) begin
            // Idle gap ends a message that has no end character.
            rx_st_q     <= RX_OFF;
            rx_done_irq <= 1'b1;
            rx_msg_len  <= rx_wr_addr;
          end
        end
        default: rx_st_q <= RX_OFF;
      endcase
    end
  end

  // ************************************************************
  // Message transmitter
  // ************************************************************
  reg [1:0]  tx_st_q;
  reg [7:0]  tx_left_q;
  reg [10:0] tx_sh_q;
  reg [3:0]  tx_bit_q;
  reg [23:0] tx_cnt_q;
  reg        tx_load_q;
  wire [3:0] tx_nbits = ctl[`UCTL_PARITY_EN] ? `DATA_BITS + 4'h3 : `DATA_BITS + 4'h2;

  assign tx_busy = (tx_st_q != TX_IDLE);

  always @(posedge clk) begin
    tx_done_irq <= 1'b0;
    if (!resetn || !user_mode) begin
      tx_st_q    <= TX_IDLE;
      tx_left_q  <= 8'h00;
      tx_rd_addr <= 8'h00;
      tx_sh_q    <= 11'h7FF;
      tx_bit_q   <= 4'h0;
      tx_cnt_q   <= 24'h000000;
      tx_load_q  <= 1'b0;
      txd_pin    <= 1'b1;
    end else begin
      case (tx_st_q)
        TX_IDLE: begin
          txd_pin <= 1'b1;
          if (message_transmit_op && tx_len != 8'h00) begin
            tx_st_q    <= TX_WAIT;
            tx_left_q  <= tx_len;
            tx_rd_addr <= 8'h00;
          end
        end
        TX_WAIT: begin
          if (turn_q == 24'h000000 && !rx_act_q) begin
            tx_st_q   <= TX_SEND;
            tx_load_q <= 1'b1;
          end
        end
        TX_SEND: begin
          if (tx_load_q) begin
            tx_load_q <= 1'b0;
            tx_sh_q   <= ctl[`UCTL_PARITY_EN] ?
                         {1'b1, par_of(tx_rd_data, ctl[`UCTL_PARITY_ODD]), tx_rd_data, 1'b0} :
                         {2'b11, tx_rd_data, 1'b0};
            tx_bit_q  <= 4'h0;
            tx_cnt_q  <= 24'h000000;
          end else if (tx_cnt_q != 24'h000000) begin
            tx_cnt_q <= tx_cnt_q - 24'h000001;
          end else if (tx_bit_q == tx_nbits) begin
            tx_left_q  <= tx_left_q - 8'h01;
            tx_rd_addr <= tx_rd_addr + 8'h01;
            if (tx_left_q == 8'h01) begin
              tx_st_q     <= TX_IDLE;
              tx_done_irq <= 1'b1;
            end else
              tx_load_q <= 1'b1;
          end else begin
            txd_pin  <= tx_sh_q[0];
            tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
            tx_bit_q <= tx_bit_q + 4'h1;
            tx_cnt_q <= BAUD_DIV - 24'h000001;
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end
endmodule // user_serial_port

// ===== rtl/user_serial_port_regs.vh
// Constants for the user-defined serial port: control byte fields, framing and timing.
`ifndef USER_SERIAL_PORT_REGS_VH
`define USER_SERIAL_PORT_REGS_VH
// Control byte fields (one control byte per port).
`define UCTL_ENABLE_BIT   0
`define UCTL_PARITY_EN    1
`define UCTL_PARITY_ODD   2
// Framing.
`define DATA_BITS         4'h8
`define MAX_MSG_LEN       8'hFF
// Baud limits in baud.
`define BAUD_MIN          1200
`define BAUD_MAX          115200
// Turnaround time at 1200 baud in microseconds (14.0 ms).
`define TURNAROUND_US     14000
`define CLK_MHZ           100
`define TURNAROUND_CYC    (`TURNAROUND_US * `CLK_MHZ)
`define BAUD_DIV_DEFAULT  (`CLK_MHZ * 1000000 / 9600)
// Quiet line time that ends a message when no end character is set.
`define IDLE_END_DEFAULT  24'h00C350
`endif

// ===== dv/user_serial_port_properties.sv
// Port-level checker for the user-defined serial port.
`timescale 1ns/1ps
module user_serial_port_checker (
  input wire       clk,
  input wire       resetn,
  input wire       run_mode,
  input wire       port_sel,
  input wire [7:0] port0_user_mode_control,
  input wire [7:0] port1_user_mode_control,
  input wire       message_transmit_op,
  input wire [7:0] tx_len,
  input wire       tx_busy,
  input wire       tx_done_irq,
  input wire       rx_chr_irq,
  input wire       default_programming_protocol,
  input wire       txd_pin
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // The enable bit of whichever control byte the port select picks.
  wire user_en = port_sel ? port1_user_mode_control[0] : port0_user_mode_control[0];
  AST_MODE: assert property (default_programming_protocol == !(run_mode && user_en))
    else $error("protocol select wrong");
  AST_IDLE_LINE: assert property (default_programming_protocol |=> txd_pin)
    else $error("line not idle outside user mode");
  AST_NO_TX: assert property (default_programming_protocol |=> !tx_busy)
    else $error("transmitter busy outside user mode");
  AST_TAKE: assert property (message_transmit_op && !tx_busy && !default_programming_protocol && tx_len != 8'h00 |=> tx_busy)
    else $error("transmit request not taken");
  AST_DONE_END: assert property (tx_done_irq |-> $past(tx_busy))
    else $error("done without transmission");
  AST_DONE_PULSE: assert property (tx_done_irq |=> !tx_done_irq)
    else $error("done pulse too long");
  // Bound covers a character in reception plus the turnaround wait.
  AST_START: assert property ($rose(tx_busy) |-> ##[1:400] (!txd_pin || !tx_busy))
    else $error("no start bit");
  AST_RX_OFF: assert property (default_programming_protocol |=> !rx_chr_irq)
    else $error("character event outside user mode");
  // A character taken while the transmitter is idle keeps the line quiet; eight cycles is below any turnaround.
  AST_TURNAROUND: assert property (rx_chr_irq && !tx_busy |-> txd_pin[*8])
    else $error("transmit too soon after receive");
endmodule // user_serial_port_checker
bind user_serial_port user_serial_port_checker chk (.clk, .resetn, .run_mode, .port_sel, .port0_user_mode_control,
  .port1_user_mode_control, .message_transmit_op, .tx_len, .tx_busy, .tx_done_irq, .rx_chr_irq,
  .default_programming_protocol, .txd_pin);

// ===== dv/serial_device.sv
// Behavioural serial device on the far side of the port.
`timescale 1ns/1ps
module serial_device #(parameter int BIT_NS = 80) (
  input  wire txd,
  output reg  rxd
);
  logic [7:0] got [$];
  logic [7:0] sh;
  initial rxd = 1'b1;
  task automatic send(input logic [7:0] c);
    rxd = 1'b0;
    #BIT_NS;
    for (int i = 0; i < 8; i++) begin
      rxd = c[i];
      #BIT_NS;
    end
    rxd = 1'b1;
    #BIT_NS;
  endtask
  task automatic send_par(input logic [7:0] c, input logic p);
    rxd = 1'b0;
    #BIT_NS;
    for (int i = 0; i < 8; i++) begin
      rxd = c[i];
      #BIT_NS;
    end
    rxd = p;
    #BIT_NS;
    rxd = 1'b1;
    #BIT_NS;
  endtask
  // mid-bit sampling. Frames with a bad stop bit are dropped.
  always @(negedge txd) begin
    #(BIT_NS / 2);
    if (!txd) begin
      for (int i = 0; i < 8; i++) begin
        #BIT_NS;
        sh[i] = txd;
      end
      #BIT_NS;
      if (txd) got.push_back(sh);
    end
  end
endmodule // serial_device

// ===== dv/testbench.sv
// Self-checking testbench for the user-defined serial port.
`timescale 1ns/1ps
module testbench;
  logic       clk, resetn, run_mode, port_sel, message_transmit_op, message_receive_op, rx_start_chr_en;
  logic       rx_end_chr_en, tx_busy, tx_done_irq, rx_chr_irq, rx_wr_en, rx_done_irq, rxd_pin, txd_pin;
  logic       default_programming_protocol;
  logic [7:0] port0_user_mode_control, port1_user_mode_control, tx_len, tx_rd_addr, tx_rd_data, rx_chr;
  logic [7:0] rx_start_chr, rx_end_chr, rx_wr_addr, rx_wr_data, rx_msg_len;
  logic [7:0] buf_q [0:255];
  logic [7:0] rbuf [0:255];
  logic [15:0] rows [0:4] = '{16'h0000, 16'hFFFF, 16'hA5A5, 16'h5A5A, 16'h0D0D};
  int         errors, compares, n;
  assign tx_rd_data = buf_q[tx_rd_addr];
  // Receive buffer as the program would see it; taken on the falling edge, away from the launching edge.
  always @(negedge clk)
    if (rx_wr_en === 1'b1) rbuf[rx_wr_addr] <= rx_wr_data;
  user_serial_port #(.BAUD_DIV(24'h000008), .TURNAROUND_CYC(24'h000014), .IDLE_END_CYC(24'h000064)) dut (
    .clk, .resetn, .run_mode, .port_sel, .port0_user_mode_control, .port1_user_mode_control,
    .message_transmit_op, .tx_len, .tx_rd_addr, .tx_rd_data, .tx_busy, .tx_done_irq, .message_receive_op,
    .rx_start_chr_en, .rx_start_chr, .rx_end_chr_en, .rx_end_chr, .rx_chr_irq, .rx_chr, .rx_wr_en,
    .rx_wr_addr, .rx_wr_data, .rx_done_irq, .rx_msg_len, .default_programming_protocol, .rxd_pin, .txd_pin);
  serial_device dev (.txd(txd_pin), .rxd(rxd_pin));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic end_sim;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  // Bounded wait on one of the three event pulses, seen just after the edge.
  task automatic wait_on(input int k);
    int i;
    for (i = 0; i < 4000; i++) begin
      @(posedge clk);
      #1;
      if ((k == 0 && tx_done_irq === 1'b1) || (k == 1 && rx_chr_irq === 1'b1) || (k == 2 && rx_done_irq === 1'b1))
        break;
    end
    if (i == 4000) begin
      cmp("wait", 8'h01, 8'h00);
      end_sim();
    end
  endtask
  task automatic pulse(input int k);
    @(posedge clk);
    #1;
    if (k == 0) message_transmit_op = 1'b1;
    else message_receive_op = 1'b1;
    @(posedge clk);
    #1;
    message_transmit_op = 1'b0;
    message_receive_op = 1'b0;
  endtask
  initial begin
    {resetn, port_sel, message_transmit_op, message_receive_op, rx_start_chr_en, rx_end_chr_en} = 6'h00;
    {run_mode, port0_user_mode_control, port1_user_mode_control} = {1'b1, 8'h01, 8'h00};
    {tx_len, rx_start_chr, rx_end_chr} = {8'h03, 8'h02, 8'h0D};
    {buf_q[0], buf_q[1], buf_q[2]} = {8'h31, 8'hC2, 8'h33};
    repeat (8) @(posedge clk);
    #1 resetn = 1'b1;
    // Ordinary cases: each character sent in must come out unchanged.
    foreach (rows[r]) begin
      fork dev.send(rows[r][15:8]); join_none
      wait_on(1);
      cmp("rx_chr", rows[r][7:0], rx_chr);
      wait fork;
    end
    pulse(0);
    tx_len = 8'h05;
    pulse(0);
    wait_on(0);
    for (n = 0; n < 3; n++) cmp("tx_chr", buf_q[n], dev.got[n]);
    repeat (150) @(posedge clk);
    cmp("tx_count", 8'h03, 8'(dev.got.size()));
    pulse(1);
    dev.send(8'h41);
    fork dev.send(8'h42); join_none
    wait_on(2);
    cmp("rx_msg_len", 8'h02, rx_msg_len);
    cmp("rx_buf1", 8'h41, rbuf[1]);
    cmp("rx_buf2", 8'h42, rbuf[2]);
    // Start and end characters frame the message; a character before the start is dropped.
    {rx_start_chr_en, rx_end_chr_en} = 2'b11;
    pulse(1);
    dev.send(8'h41);
    dev.send(8'h02);
    dev.send(8'h55);
    fork dev.send(8'h0D); join_none
    wait_on(2);
    wait fork;
    @(posedge clk);
    #1 cmp("rx_msg_len", 8'h03, rx_msg_len);
    cmp("rx_buf1", 8'h02, rbuf[1]);
    cmp("rx_buf2", 8'h55, rbuf[2]);
    cmp("rx_buf3", 8'h0D, rbuf[3]);
    // Even parity: the first frame carries a wrong parity bit and must be dropped.
    port0_user_mode_control = 8'h03;
    fork
      begin
        dev.send_par(8'h07, 1'b0);
        dev.send_par(8'h03, 1'b0);
      end
    join_none
    wait_on(1);
    cmp("rx_par", 8'h03, rx_chr);
    wait fork;
    // A reset in mid-run drops a transmission that still waits for the turnaround.
    pulse(0);
    cmp("tx_busy", 8'h01, {7'h00, tx_busy});
    resetn = 1'b0;
    repeat (3) @(posedge clk);
    #1 cmp("rst_busy", 8'h00, {7'h00, tx_busy});
    cmp("rst_txd", 8'h01, {7'h00, txd_pin});
    resetn = 1'b1;
    @(posedge clk);
    #1 run_mode = 1'b0;
    #1 cmp("stop_mode", 8'h01, {7'h00, default_programming_protocol});
    @(posedge clk);
    #1 {run_mode, port_sel} = 2'b11;
    #1 cmp("port1_off", 8'h01, {7'h00, default_programming_protocol});
    @(posedge clk);
    #1 port1_user_mode_control = 8'h01;
    #1 cmp("port1_on", 8'h00, {7'h00, default_programming_protocol});
    end_sim();
  end
endmodule // testbench
